// ==== hw/mdfsr_regs.v ====
// motion displacement and frame statistics registers behind the serial port
//
// Summary of operation
// RULE1 - X low byte: scaled counts, cleared on read
// RULE2 - Y low byte at 0x04, cleared on read
// RULE3 - low bytes are two's complement bits 7:0
// RULE4 - shared high register 0x05 holds upper nibbles
// RULE5 - high bits 7:4 X, bits 3:0 Y
// RULE6 - read high after lows; registers then cleared
// RULE7 - controller reads 0x02 to 0x05 in order
// RULE8 - surface count 0x06: upper 8 of 9 bits
// RULE9 - surface count capped at 242, near zero idle
// RULE10 - 16-bit exposure in cycles, auto adjusted
// RULE11 - controller reads 0x07 then 0x08 immediately
// RULE12 - high exposure read captures matching low byte
// RULE13 - peak level 0x09 within 0 to 254
// RULE14 - total is 18-bit frame sum over 1024
// RULE15 - total stays within 0 to 167
// RULE16 - statistics update together at frame end
// RULE17 - floor level is frame minimum, 0 to 254
// RULE18 - write to 0x02 clears flags and displacement
// RULE19 - overflow sets flag, freezes until read out
`timescale 1ns/1ps
`default_nettype none
`include "mdfsr_defs.vh"
module mdfsr_regs (
    input  wire        CORE_CLK_I,
    input  wire        RESET_I,
    input  wire        SCLK_I,
    input  wire        CS_N_I,
    input  wire        MOSI_I,
    output reg         MISO_O,
    output reg         MISO_OE_N_O,
    input  wire        MOVE_VALID_I,
    input  wire [7:0]  MOVE_DX_I,
    input  wire [7:0]  MOVE_DY_I,
    input  wire [1:0]  RES_SEL_I,
    input  wire        PIX_VALID_I,
    input  wire [7:0]  PIX_DATA_I,
    input  wire        FRAME_END_I,
    input  wire [8:0]  FEATURE_COUNT_I,
    output reg  [15:0] SHUTTER_O,
    output reg         MOVEMENT_PENDING_O,
    output reg         ACCUM_OVERFLOW_O
);
    // serial port state
    wire        sclk_s;
    wire        cs_n_s;
    wire        mosi_s;
    wire        sclk_lo_s;
    wire        cs_on_s;
    reg         sclk_d_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  cmd_reg;
    reg         data_phase_reg;
    reg         done_reg;
    reg  [7:0]  tx_reg;
    wire        rise;
    wire        fall;
    wire        byte_done;
    wire [7:0]  rx_byte;
    wire        addr_byte;
    wire        rd_now;
    wire        wr_now;
    wire [6:0]  rd_addr;
    reg  [7:0]  rd_data;

    // displacement state
    wire [11:0] x_acc;
    wire [11:0] y_acc;
    wire        x_ovf;
    wire        y_ovf;
    reg  [11:0] dx_scaled;
    reg  [11:0] dy_scaled;
    reg  [3:0]  x_nib_reg;
    reg  [3:0]  y_nib_reg;
    wire        clr_all;
    wire        clr_x;
    wire        clr_y;
    wire        move_nz;

    // frame statistics state
    reg  [7:0]  surface_reg;
    reg  [7:0]  peak_reg;
    reg  [7:0]  floor_reg;
    reg  [7:0]  total_reg;
    reg  [7:0]  exp_low_shadow_reg;
    reg         exp_shadow_valid_reg;
    reg  [7:0]  run_max_reg;
    reg  [7:0]  run_min_reg;
    reg  [17:0] run_sum_reg;
    reg  [7:0]  pix_clip;
    reg  [7:0]  cur_max;
    reg  [7:0]  cur_min;
    reg  [17:0] cur_sum;
    reg  [7:0]  cur_total;
    reg  [7:0]  cur_surface;
    reg  [15:0] exp_step;
    reg  [15:0] shutter_next;

    // pins from the controller cross into the core clock first
    mdfsr_sync u_sync_sclk (
        .clk_i (CORE_CLK_I),
        .rst_i (RESET_I),
        .d_i   (~SCLK_I),
        .q_o   (sclk_lo_s)
    );
    mdfsr_sync u_sync_cs (
        .clk_i (CORE_CLK_I),
        .rst_i (RESET_I),
        .d_i   (~CS_N_I),
        .q_o   (cs_on_s)
    );

    // clock and select cross inverted so a flushed synchroniser reads as idle:
    // no false serial edge and no phantom select right after reset
    assign sclk_s = !sclk_lo_s;
    assign cs_n_s = !cs_on_s;
    mdfsr_sync u_sync_mosi (
        .clk_i (CORE_CLK_I),
        .rst_i (RESET_I),
        .d_i   (MOSI_I),
        .q_o   (mosi_s)
    );

    // edges of the synchronised serial clock, gated by select
    assign rise = !cs_n_s && sclk_s && !sclk_d_reg;
    assign fall = !cs_n_s && !sclk_s && sclk_d_reg;
    assign byte_done = rise && (bit_cnt_reg == `MDFSR_BYTE_BITS - 4'h1)
                       && !done_reg;
    assign rx_byte = {shift_reg[6:0], mosi_s};
    assign addr_byte = byte_done && !data_phase_reg;
    assign rd_now = addr_byte && !rx_byte[`MDFSR_WR_BIT];
    assign wr_now = byte_done && data_phase_reg
                    && cmd_reg[`MDFSR_WR_BIT];
    assign rd_addr = rx_byte[`MDFSR_ADDR_W-1:0];

    // bit counter, shift register and frame phase
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            sclk_d_reg     <= 1'b1;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            cmd_reg        <= 8'h00;
            data_phase_reg <= 1'b0;
            done_reg       <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            if (cs_n_s) begin
                bit_cnt_reg    <= 4'h0;
                data_phase_reg <= 1'b0;
                done_reg       <= 1'b0;
            end else if (rise && !done_reg) begin
                shift_reg <= rx_byte;
                if (byte_done) begin
                    bit_cnt_reg <= 4'h0;
                    if (data_phase_reg) begin
                        done_reg <= 1'b1; // one byte per select
                    end else begin
                        cmd_reg        <= rx_byte;
                        data_phase_reg <= 1'b1;
                    end
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end
        end
    end

    // read mux, sampled once when the address byte completes
    always @* begin
        case (rd_addr)
            `MDFSR_ADDR_X_LOW:    rd_data = x_acc[7:0]; // [RULE1] [RULE3]
            `MDFSR_ADDR_Y_LOW:    rd_data = y_acc[7:0]; // [RULE2] [RULE3]
            `MDFSR_ADDR_XY_HIGH:  rd_data = {x_nib_reg, y_nib_reg}; // [RULE5]
            `MDFSR_ADDR_SURFACE:  rd_data = surface_reg;
            `MDFSR_ADDR_EXP_HIGH: rd_data = SHUTTER_O[15:8];
            `MDFSR_ADDR_EXP_LOW:  rd_data = exp_shadow_valid_reg ?
                                      exp_low_shadow_reg :
                                      SHUTTER_O[7:0]; // [RULE12]
            `MDFSR_ADDR_PEAK:     rd_data = peak_reg;
            `MDFSR_ADDR_TOTAL:    rd_data = total_reg;
            `MDFSR_ADDR_FLOOR:    rd_data = floor_reg;
            default:              rd_data = `MDFSR_UNMAPPED;
        endcase
    end

    // read data leaves msb first, one bit per falling serial edge
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            tx_reg      <= 8'h00;
            MISO_O      <= 1'b0;
            MISO_OE_N_O <= 1'b1;
        end else if (cs_n_s) begin
            MISO_OE_N_O <= 1'b1; // released while deselected
            MISO_O      <= 1'b0;
        end else if (rd_now) begin
            tx_reg      <= rd_data;
            MISO_OE_N_O <= 1'b0;
        end else if (fall && data_phase_reg && !cmd_reg[`MDFSR_WR_BIT]) begin
            MISO_O <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // counts scaled by the resolution step: 1x to 4x of the base rate
    always @* begin
        case (RES_SEL_I)
            2'b00:   dx_scaled = {{4{MOVE_DX_I[7]}}, MOVE_DX_I};
            2'b01:   dx_scaled = {{3{MOVE_DX_I[7]}}, MOVE_DX_I, 1'b0};
            2'b10:   dx_scaled = {{4{MOVE_DX_I[7]}}, MOVE_DX_I}
                               + {{3{MOVE_DX_I[7]}}, MOVE_DX_I, 1'b0};
            default: dx_scaled = {{2{MOVE_DX_I[7]}}, MOVE_DX_I, 2'b00};
        endcase
        case (RES_SEL_I)
            2'b00:   dy_scaled = {{4{MOVE_DY_I[7]}}, MOVE_DY_I};
            2'b01:   dy_scaled = {{3{MOVE_DY_I[7]}}, MOVE_DY_I, 1'b0};
            2'b10:   dy_scaled = {{4{MOVE_DY_I[7]}}, MOVE_DY_I}
                               + {{3{MOVE_DY_I[7]}}, MOVE_DY_I, 1'b0};
            default: dy_scaled = {{2{MOVE_DY_I[7]}}, MOVE_DY_I, 2'b00};
        endcase
    end

    // clear sources: any write to motion, or a low-byte read
    assign clr_all = wr_now
                     && (cmd_reg[`MDFSR_ADDR_W-1:0] == `MDFSR_ADDR_MOTION);
    assign clr_x = clr_all
                   || (rd_now && rd_addr == `MDFSR_ADDR_X_LOW); // [RULE1]
    assign clr_y = clr_all
                   || (rd_now && rd_addr == `MDFSR_ADDR_Y_LOW); // [RULE2]
    assign move_nz = MOVE_VALID_I
                     && (MOVE_DX_I != 8'h00 || MOVE_DY_I != 8'h00);

    mdfsr_axis_acc u_acc_x (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RESET_I),
        .add_i   (MOVE_VALID_I),
        .delta_i (dx_scaled),
        .clear_i (clr_x),
        .hold_i  (ACCUM_OVERFLOW_O), // [RULE19]
        .acc_o   (x_acc),
        .ovf_o   (x_ovf)
    );
    mdfsr_axis_acc u_acc_y (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RESET_I),
        .add_i   (MOVE_VALID_I),
        .delta_i (dy_scaled),
        .clear_i (clr_y),
        .hold_i  (ACCUM_OVERFLOW_O), // [RULE19]
        .acc_o   (y_acc),
        .ovf_o   (y_ovf)
    );

    // high nibbles are caught by the low reads so the pair stays whole
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            x_nib_reg <= 4'h0;
            y_nib_reg <= 4'h0;
        end else begin
            if (clr_all) begin
                x_nib_reg <= 4'h0; // [RULE18]
                y_nib_reg <= 4'h0;
            end else if (rd_now && rd_addr == `MDFSR_ADDR_XY_HIGH) begin
                x_nib_reg <= 4'h0; // [RULE6]
                y_nib_reg <= 4'h0;
            end else begin
                if (clr_x) begin
                    x_nib_reg <= x_acc[`MDFSR_NIB_HI:`MDFSR_NIB_LO]; // [RULE4]
                end
                if (clr_y) begin
                    y_nib_reg <= y_acc[`MDFSR_NIB_HI:`MDFSR_NIB_LO]; // [RULE4]
                end
            end
        end
    end

    // flags: new motion or overflow in the clearing cycle wins
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            MOVEMENT_PENDING_O <= 1'b0;
            ACCUM_OVERFLOW_O   <= 1'b0;
        end else begin
            if (move_nz) begin
                MOVEMENT_PENDING_O <= 1'b1;
            end else if (clr_all || (rd_now
                         && rd_addr == `MDFSR_ADDR_XY_HIGH)) begin
                MOVEMENT_PENDING_O <= 1'b0; // [RULE18] [RULE6]
            end
            if (x_ovf || y_ovf) begin
                ACCUM_OVERFLOW_O <= 1'b1; // [RULE19]
            end else if (clr_all || (rd_now
                         && rd_addr == `MDFSR_ADDR_XY_HIGH)) begin
                ACCUM_OVERFLOW_O <= 1'b0; // [RULE19] [RULE18]
            end
        end
    end

    // running frame figures including a pixel that lands on frame end
    always @* begin
        pix_clip = (PIX_DATA_I > `MDFSR_PIXEL_MAX) ?
                   `MDFSR_PIXEL_MAX : PIX_DATA_I; // [RULE13] [RULE17]
        cur_max = run_max_reg;
        cur_min = run_min_reg;
        cur_sum = run_sum_reg;
        if (PIX_VALID_I) begin
            if (pix_clip > run_max_reg) begin
                cur_max = pix_clip;
            end
            if (pix_clip < run_min_reg) begin
                cur_min = pix_clip;
            end
            cur_sum = run_sum_reg + {10'h000, pix_clip};
        end
        // total is the sum over 1024, held within its printed range
        cur_total = (cur_sum[`MDFSR_SUM_HI:`MDFSR_SUM_LO] > `MDFSR_TOTAL_MAX) ?
                    `MDFSR_TOTAL_MAX :
                    cur_sum[`MDFSR_SUM_HI:`MDFSR_SUM_LO]; // [RULE14] [RULE15]
        cur_surface = (FEATURE_COUNT_I[8:1] > `MDFSR_SURFACE_MAX) ?
                      `MDFSR_SURFACE_MAX :
                      FEATURE_COUNT_I[8:1]; // [RULE8] [RULE9]
    end

    // exposure regulation: step of one sixteenth, at least one cycle
    always @* begin
        exp_step = SHUTTER_O >> `MDFSR_EXP_STEP_SH;
        if (exp_step == 16'h0000) begin
            exp_step = 16'h0001;
        end
        shutter_next = SHUTTER_O;
        if (cur_max > `MDFSR_PEAK_HIGH || cur_total > `MDFSR_TOTAL_HIGH) begin
            shutter_next = (SHUTTER_O < `MDFSR_EXP_MIN + exp_step) ?
                           `MDFSR_EXP_MIN : SHUTTER_O - exp_step; // [RULE10]
        end else if (cur_max < `MDFSR_PEAK_LOW
                     && cur_total < `MDFSR_TOTAL_LOW) begin
            shutter_next = (SHUTTER_O > `MDFSR_EXP_MAX - exp_step) ?
                           `MDFSR_EXP_MAX : SHUTTER_O + exp_step; // [RULE10]
        end
    end

    // per-frame accumulation and a joint update at frame end
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            run_max_reg <= 8'h00;
            run_min_reg <= `MDFSR_FLOOR_INIT;
            run_sum_reg <= 18'h00000;
            surface_reg <= `MDFSR_RST_SURFACE;
            peak_reg    <= `MDFSR_RST_PEAK;
            floor_reg   <= `MDFSR_RST_FLOOR;
            total_reg   <= `MDFSR_RST_TOTAL;
            SHUTTER_O   <= `MDFSR_RST_EXPOSURE;
        end else if (FRAME_END_I) begin
            surface_reg <= cur_surface; // [RULE16]
            peak_reg    <= cur_max; // [RULE13]
            floor_reg   <= (cur_min == `MDFSR_FLOOR_INIT) ?
                           8'h00 : cur_min; // [RULE17]
            total_reg   <= cur_total; // [RULE15]
            SHUTTER_O   <= shutter_next; // [RULE16]
            run_max_reg <= 8'h00;
            run_min_reg <= `MDFSR_FLOOR_INIT;
            run_sum_reg <= 18'h00000;
        end else begin
            run_max_reg <= cur_max;
            run_min_reg <= cur_min;
            run_sum_reg <= cur_sum;
        end
    end

    // low exposure byte frozen by the high read, released by its own read
    always @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            exp_low_shadow_reg   <= `MDFSR_RST_EXP_LOW;
            exp_shadow_valid_reg <= 1'b0;
        end else if (rd_now && rd_addr == `MDFSR_ADDR_EXP_HIGH) begin
            exp_low_shadow_reg   <= SHUTTER_O[7:0]; // [RULE12]
            exp_shadow_valid_reg <= 1'b1;
        end else if (rd_now && rd_addr == `MDFSR_ADDR_EXP_LOW) begin
            exp_shadow_valid_reg <= 1'b0;
        end
    end
endmodule // mdfsr_regs
`default_nettype wire

// ==== hw/mdfsr_defs.vh ====
// register map, field layout, reset values and limits of the motion stats bank
`ifndef MDFSR_DEFS_VH
`define MDFSR_DEFS_VH

// serial frame layout
`define MDFSR_BYTE_BITS     4'h8
`define MDFSR_WR_BIT        7
`define MDFSR_ADDR_W        7

// register offsets
`define MDFSR_ADDR_MOTION   7'h02
`define MDFSR_ADDR_X_LOW    7'h03
`define MDFSR_ADDR_Y_LOW    7'h04
`define MDFSR_ADDR_XY_HIGH  7'h05
`define MDFSR_ADDR_SURFACE  7'h06
`define MDFSR_ADDR_EXP_HIGH 7'h07
`define MDFSR_ADDR_EXP_LOW  7'h08
`define MDFSR_ADDR_PEAK     7'h09
`define MDFSR_ADDR_TOTAL    7'h0a
`define MDFSR_ADDR_FLOOR    7'h0b

// reset values
`define MDFSR_RST_SURFACE   8'h00
`define MDFSR_RST_EXPOSURE  16'h0064
`define MDFSR_RST_EXP_LOW   8'h64
`define MDFSR_RST_PEAK      8'hd0
`define MDFSR_RST_TOTAL     8'h80
`define MDFSR_RST_FLOOR     8'h00
`define MDFSR_UNMAPPED      8'h00

// value limits of the frame statistics
`define MDFSR_SURFACE_MAX   8'hf2
`define MDFSR_PIXEL_MAX     8'hfe
`define MDFSR_TOTAL_MAX     8'ha7
`define MDFSR_FLOOR_INIT    8'hff
`define MDFSR_SUM_W         18
`define MDFSR_SUM_HI        17
`define MDFSR_SUM_LO        10

// exposure regulation targets and bounds
`define MDFSR_PEAK_HIGH     8'he0
`define MDFSR_PEAK_LOW      8'h80
`define MDFSR_TOTAL_HIGH    8'h78
`define MDFSR_TOTAL_LOW     8'h30
`define MDFSR_EXP_MIN       16'h0010
`define MDFSR_EXP_MAX       16'hfff0
`define MDFSR_EXP_STEP_SH   4

// displacement layout
`define MDFSR_MOVE_W        12
`define MDFSR_NIB_HI        11
`define MDFSR_NIB_LO        8

`endif

// ==== hw/mdfsr_sync.v ====
// two-flip-flop synchroniser for one level from outside the core clock
`timescale 1ns/1ps
`default_nettype none
module mdfsr_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire d_i,
    output reg  q_o
);
    reg meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // mdfsr_sync
`default_nettype wire

// ==== hw/mdfsr_axis_acc.v ====
// one 12-bit two's complement displacement accumulator with overflow detect
`timescale 1ns/1ps
`default_nettype none
`include "mdfsr_defs.vh"
module mdfsr_axis_acc (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        add_i,
    input  wire [11:0] delta_i,
    input  wire        clear_i,
    input  wire        hold_i,
    output reg  [11:0] acc_o,
    output wire        ovf_o
);
    wire [12:0] sum;

    // one extra bit shows a signed wrap of the 12-bit range
    assign sum = {acc_o[`MDFSR_NIB_HI], acc_o} +
                 {delta_i[`MDFSR_NIB_HI], delta_i};
    assign ovf_o = add_i && !hold_i && !clear_i &&
                   (sum[12] != sum[`MDFSR_NIB_HI]);

    // a clear keeps motion that meets it, unless an overflow froze the axis
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_o <= 12'h000;
        end else if (clear_i) begin
            acc_o <= (add_i && !hold_i) ? delta_i : 12'h000; // [RULE19]
        end else if (add_i && !hold_i && !ovf_o) begin
            acc_o <= sum[11:0];
        end
    end
endmodule // mdfsr_axis_acc
`default_nettype wire

// ==== verif/mdfsr_regs_monitor.sv ====
// checker on the ports of the motion stats register bank
`timescale 1ns/1ps
`default_nettype none
module mdfsr_regs_monitor (
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_I,
    input wire logic        CS_N_I,
    input wire logic        MISO_OE_N_O,
    input wire logic        MOVE_VALID_I,
    input wire logic        PIX_VALID_I,
    input wire logic [7:0]  PIX_DATA_I,
    input wire logic        FRAME_END_I,
    input wire logic [15:0] SHUTTER_O,
    input wire logic        MOVEMENT_PENDING_O,
    input wire logic        ACCUM_OVERFLOW_O
);
    logic [3:0]  idle;
    logic [1:0]  age;
    logic [7:0]  px, pk, pk_now;
    logic [17:0] sum, sum_now;
    // running frame peak and sum, pixel above 254 counts as 254
    assign px = (PIX_DATA_I == 8'hff) ? 8'hfe : PIX_DATA_I;
    assign pk_now = (PIX_VALID_I && px > pk) ? px : pk;
    assign sum_now = sum + (PIX_VALID_I ? {10'h000, px} : 18'h00000);
    // idle select time saturates so long quiet spells stay cheap
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || !CS_N_I) idle <= 4'h0;
        else if (idle != 4'hf) idle <= idle + 4'h1;
        if (RESET_I) age <= 2'h3;
        else if (MOVE_VALID_I) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
        if (RESET_I || FRAME_END_I) begin
            pk <= 8'h00;
            sum <= 18'h00000;
        end else begin
            pk <= pk_now;
            sum <= sum_now;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    property p_rst;
        disable iff (1'b0) RESET_I |=> MISO_OE_N_O && !MOVEMENT_PENDING_O
            && !ACCUM_OVERFLOW_O && SHUTTER_O == 16'h0064;
    endproperty
    property p_oe_idle;
        idle > 4'h5 |-> MISO_OE_N_O;
    endproperty
    property p_oe_cs;
        $fell(MISO_OE_N_O) |-> !CS_N_I;
    endproperty
    property p_ovf_hold;
        idle > 4'h5 && ACCUM_OVERFLOW_O |=> ACCUM_OVERFLOW_O;
    endproperty
    property p_mot_hold;
        idle > 4'h5 && MOVEMENT_PENDING_O |=> MOVEMENT_PENDING_O;
    endproperty
    property p_mot_src;
        $rose(MOVEMENT_PENDING_O) |-> age < 2'h3;
    endproperty
    property p_shut_when;
        !$stable(SHUTTER_O) |-> $past(FRAME_END_I);
    endproperty
    property p_shut_rng;
        SHUTTER_O >= 16'h0010 && SHUTTER_O <= 16'hfff0;
    endproperty
    property p_shut_dn;
        FRAME_END_I && (pk_now > 8'he0 || sum_now[17:10] > 8'h78) |=>
            SHUTTER_O < $past(SHUTTER_O) || SHUTTER_O == 16'h0010;
    endproperty
    property p_shut_up;
        FRAME_END_I && pk_now < 8'h80 && sum_now[17:10] < 8'h30 |=>
            SHUTTER_O > $past(SHUTTER_O) || SHUTTER_O == 16'hfff0;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    a_oe_cs: assert property (p_oe_cs) else $error("oe no select");
    a_ovf_hold: assert property (p_ovf_hold) else $error("ovf");
    a_mot_hold: assert property (p_mot_hold) else $error("mot");
    a_mot_src: assert property (p_mot_src) else $error("mot src");
    a_shut_when: assert property (p_shut_when) else $error("sh");
    a_shut_rng: assert property (p_shut_rng) else $error("sh rng");
    a_shut_dn: assert property (p_shut_dn) else $error("sh dn");
    a_shut_up: assert property (p_shut_up) else $error("sh up");
    c_ovf: cover property ($rose(ACCUM_OVERFLOW_O));
    c_read: cover property ($fell(MISO_OE_N_O));
    c_dn: cover property (FRAME_END_I && pk_now > 8'he0);
endmodule // mdfsr_regs_monitor
bind mdfsr_regs mdfsr_regs_monitor u_mon (
    .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .CS_N_I(CS_N_I),
    .MISO_OE_N_O(MISO_OE_N_O), .MOVE_VALID_I(MOVE_VALID_I),
    .PIX_VALID_I(PIX_VALID_I), .PIX_DATA_I(PIX_DATA_I),
    .FRAME_END_I(FRAME_END_I), .SHUTTER_O(SHUTTER_O),
    .MOVEMENT_PENDING_O(MOVEMENT_PENDING_O),
    .ACCUM_OVERFLOW_O(ACCUM_OVERFLOW_O)
);
`default_nettype wire

// ==== verif/mdfsr_mcu_model.sv ====
// serial controller model that reads and writes the register bank
`timescale 1ns/1ps
`default_nettype none
module mdfsr_mcu_model #(
    parameter int HALF = 10
) (
    input  wire logic clk_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i,
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output var  logic mosi_o
);
    // idle: clock high, device deselected
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one access per select, command then data, msb first
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b0;
            mosi_o <= sh[15-i];
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b1;
            // an undriven line spoils the byte on purpose
            if (i > 7) rd = {rd[6:0], miso_oe_n_i ? 1'bx : miso_i};
        end
        repeat (HALF) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
    endtask
endmodule // mdfsr_mcu_model
`default_nettype wire

// ==== verif/mdfsr_regs_test.sv ====
// self-checking bench for the motion stats register bank
`timescale 1ns/1ps
`default_nettype none
module mdfsr_regs_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        mv = 1'b0;
    logic        pv = 1'b0;
    logic        fe = 1'b0;
    logic [7:0]  dx = 8'h00;
    logic [7:0]  dy = 8'h00;
    logic [7:0]  pd = 8'h00;
    logic [1:0]  res = 2'h0;
    logic [8:0]  feat = 9'h000;
    logic [15:0] shut;
    logic        sclk, cs_n, mosi, miso, oe_n, movement_pending, ovf, miso_w;
    int          fail_count = 0;
    int          n_checks = 0;
    always #4 clk = ~clk;
    // a released data line shows the inverse of its last level
    assign miso_w = oe_n ? ~miso : miso;
    mdfsr_regs dut (
        .CORE_CLK_I(clk), .RESET_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
        .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_N_O(oe_n),
        .MOVE_VALID_I(mv), .MOVE_DX_I(dx), .MOVE_DY_I(dy),
        .RES_SEL_I(res), .PIX_VALID_I(pv), .PIX_DATA_I(pd),
        .FRAME_END_I(fe), .FEATURE_COUNT_I(feat), .SHUTTER_O(shut),
        .MOVEMENT_PENDING_O(movement_pending), .ACCUM_OVERFLOW_O(ovf)
    );
    mdfsr_mcu_model mcu (
        .clk_i(clk), .miso_i(miso_w), .miso_oe_n_i(oe_n),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        mcu.xfer({1'b0, a}, 8'h00, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] d;
        mcu.xfer({1'b1, a}, v, d);
    endtask
    task automatic move(input logic [7:0] x, input logic [7:0] y);
        @(posedge clk);
        mv <= 1'b1;
        dx <= x;
        dy <= y;
        @(posedge clk);
        mv <= 1'b0;
    endtask
    // n pixels of value v, then a closing pixel with the frame end
    task automatic frame(input logic [7:0] v, input int n,
                         input logic [7:0] last, input logic [8:0] f);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            pv <= 1'b1;
            pd <= v;
        end
        @(posedge clk);
        pd <= last;
        fe <= 1'b1;
        feat <= f;
        @(posedge clk);
        pv <= 1'b0;
        fe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h64, 8'hd0, 8'h80, 8'h00};
        chk(shut, 16'h0064);
        chk({movement_pending, ovf}, 16'h0000);
        for (int i = 0; i < 9; i++) rchk(7'(3 + i), e[i]);
        rchk(7'h20, 8'h00);
        $display("t_reset done");
    endtask
    // every resolution code, negative x and positive y
    task automatic t_scale;
        logic [11:0] xv, yv;
        logic [7:0]  d;
        for (int r = 0; r < 4; r++) begin
            xv = 12'(-100 * (r + 1));
            yv = 12'(100 * (r + 1));
            @(posedge clk);
            res <= 2'(r);
            move(8'h9c, 8'h64);
            repeat (3) @(posedge clk);
            chk(movement_pending, 16'h0001);
            mcu.xfer(8'h02, 8'h00, d);
            rchk(7'h03, xv[7:0]);
            rchk(7'h04, yv[7:0]);
            rchk(7'h05, {xv[11:8], yv[11:8]});
            chk(movement_pending, 16'h0000);
            rchk(7'h03, 8'h00);
        end
        $display("t_scale done");
    endtask
    task automatic t_wclr;
        move(8'h05, 8'hfb);
        wr(7'h02, 8'ha5);
        chk(movement_pending, 16'h0000);
        rchk(7'h03, 8'h00);
        rchk(7'h04, 8'h00);
        rchk(7'h05, 8'h00);
        $display("t_wclr done");
    endtask
    // x4 scale: four samples fit, the fifth would wrap
    task automatic t_ovf;
        for (int i = 0; i < 5; i++) move(8'h7f, 8'h00);
        move(8'hff, 8'h00);
        repeat (3) @(posedge clk);
        chk(ovf, 16'h0001);
        rchk(7'h03, 8'hf0);
        rchk(7'h04, 8'h00);
        rchk(7'h05, 8'h70);
        chk(ovf, 16'h0000);
        $display("t_ovf done");
    endtask
    task automatic t_frame;
        frame(8'hc8, 1000, 8'hff, 9'h1ff);
        rchk(7'h06, 8'hf2);
        rchk(7'h09, 8'hfe);
        rchk(7'h0a, 8'ha7);
        rchk(7'h0b, 8'hc8);
        chk(shut, 16'h005e);
        rchk(7'h07, 8'h00);
        rchk(7'h08, 8'h5e);
        frame(8'hc8, 599, 8'h03, 9'h0a1);
        rchk(7'h06, 8'h50);
        rchk(7'h0a, 8'h74);
        rchk(7'h0b, 8'h03);
        rchk(7'h07, 8'h00);
        frame(8'h0a, 4, 8'h0a, 9'h000);
        rchk(7'h08, 8'h5e);
        chk(shut, 16'h0063);
        rchk(7'h09, 8'h0a);
        wr(7'h09, 8'h00);
        rchk(7'h09, 8'h0a);
        $display("t_frame done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_scale();
        t_wclr();
        t_ovf();
        t_frame();
        summarize();
    end
    // hang guard
    initial begin
        #700us;
        fail_count++;
        summarize();
    end
endmodule // mdfsr_regs_test
`default_nettype wire
